// ===== logic/flash_regs_defs.svh
// Offsets, field positions, reset values and widths of the flash registers
`ifndef FLASH_REGS_DEFS_SVH
`define FLASH_REGS_DEFS_SVH
`define OFS_ACCESS_SIZE   4'h0
`define OFS_READ_WAIT     4'h4
`define OFS_STATUS        4'h8
`define OFS_EXTRA_WAIT    4'hc
`define OFS_TRIM          5'h10
`define ASZ_RESET         2'h2
`define ASZ_PROG          2'h1
`define ASZ_READ32        2'h2
`define RWT_RESET         2'h0
`define SD_RESET          3'h0
`define ST_ERR_BIT        2
`define ST_HNG_BIT        1
`define ST_RDY_BIT        0
`define TRIM_FLASH_ADDR   32'h0010_1004
`define TRIM_WIDTH        10
`define WAIT_CNT_W        4
`endif

// ===== logic/flash_regs_pkg.sv
// Types of the flash register bank; its wait-state counter keeps its own
package flash_regs_pkg;
	typedef enum logic [3:0] {
		TR_IDLE  = 4'b0001,
		TR_REQ   = 4'b0010,
		TR_DONE  = 4'b0100,
		TR_SPARE = 4'b1000
	} trim_state_t;

	typedef struct packed {
		logic [1:0] access_size;
		logic [1:0] read_wait;
		logic [2:0] extra_wait;
		logic       ecc_err;
		logic [9:0] trim;
	} ctrl_t;
endpackage : flash_regs_pkg

// ===== logic/read_wait_timer.sv
// Counts read wait states for 32-bit flash reads
module read_wait_timer (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       start_i,
	input  wire logic [3:0] waits_i,
	output logic            busy_o,
	output logic            done_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       busy;
		logic       done;
	} wt_t;
	wt_t st;
	wt_t next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (st.busy) begin
			if (st.cnt == 4'h0) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt - 4'h1;
			end
		end else if (start_i) begin
			next_st.busy = 1'b1;
			next_st.cnt = waits_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy_o = st.busy;
	assign done_o = st.done;
endmodule : read_wait_timer

// ===== logic/flash_interface_regs.sv
// Flash interface control and status register bank on Avalon-MM
`include "flash_regs_defs.svh"

// Behaviour
// - Reset loads access size field with 10, 32-bit read-only mode.
// - Access size 01 programming, 10 read-only; 00 and 11 prohibited.
// - Read wait applies only in 32-bit read mode.
// - Read wait in bits 1:0, bit 0 read-only zero.
// - ECC flag bit 2 set on correction; write 0 clears, 1 ignored.
// - Status bits 7:3 reserved, writes ignored.
// - Hang flag bit 1 shows automatic algorithm timing limit exceeded.
// - Ready flag bit 0 low while automatic write or erase runs.
// - Sync-down field 000/001/011/101/111 adds 0/1/3/5/7 waits.
// - Read waits total read wait plus sync-down waits in read mode.
// - Trim mirror holds low ten bits of flash word 0x0010_1004.
// - Chip reset clears trim mirror before reloading it.
module flash_interface_regs (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        ecc_corr_i,
	input  wire logic        hang_i,
	input  wire logic        busy_i,
	input  wire logic        flash_rd_req_i,
	output logic             flash_rd_done_o,
	output logic             prog_mode_o,
	output logic             read32_mode_o,
	output logic [3:0]       read_waits_o,
	output logic             trim_rd_o,
	input  wire logic [31:0] trim_data_i,
	input  wire logic        trim_valid_i,
	output logic [9:0]       trim_o
);
	typedef struct packed {
		flash_regs_pkg::ctrl_t       ctrl;
		flash_regs_pkg::trim_state_t trim_st;
		logic                        ack;
		logic [31:0]                 rdata;
		logic                        ecc_s1;
		logic                        ecc_s2;
		logic                        hng_s1;
		logic                        hng_s2;
		logic                        bsy_s1;
		logic                        bsy_s2;
		logic                        rdone;
		logic                        prog;
		logic                        rd32;
		logic [3:0]                  waits;
		logic                        trim_rd;
	} state_t;

	state_t st;
	state_t next_st;
	logic   req;
	logic   timer_done;
	logic   timer_busy;
	logic [3:0] total_waits;
	logic [3:0] sd_waits;

	assign req = (avs_read_i | avs_write_i) & ~st.ack;

	// Prohibited sync-down codes add nothing; odd codes give their value
	always_comb begin
		sd_waits = st.ctrl.extra_wait[0] ? {1'b0, st.ctrl.extra_wait}
			: 4'h0;
		total_waits = sd_waits + {2'b00, st.ctrl.read_wait};
	end

	read_wait_timer u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (flash_rd_req_i & st.rd32),
		.waits_i   (total_waits),
		.busy_o    (timer_busy),
		.done_o    (timer_done)
	);

	always_comb begin
		next_st = st;
		next_st.ecc_s1 = ecc_corr_i;
		next_st.ecc_s2 = st.ecc_s1;
		next_st.hng_s1 = hang_i;
		next_st.hng_s2 = st.hng_s1;
		next_st.bsy_s1 = busy_i;
		next_st.bsy_s2 = st.bsy_s1;
		next_st.ack = req;
		next_st.trim_rd = 1'b0;
		// Program mode reads take no wait states
		next_st.rdone = st.rd32 ? timer_done
			: (flash_rd_req_i & ~timer_busy);
		next_st.prog = (st.ctrl.access_size == `ASZ_PROG);
		next_st.rd32 = (st.ctrl.access_size == `ASZ_READ32);
		next_st.waits = st.rd32 ? total_waits : 4'h0;

		case (st.trim_st)
			flash_regs_pkg::TR_IDLE: begin
				next_st.trim_st = flash_regs_pkg::TR_REQ;
			end
			flash_regs_pkg::TR_REQ: begin
				next_st.trim_rd = 1'b1;
				if (trim_valid_i) begin
					next_st.ctrl.trim = trim_data_i[9:0];
					next_st.trim_st = flash_regs_pkg::TR_DONE;
					next_st.trim_rd = 1'b0;
				end
			end
			flash_regs_pkg::TR_DONE: begin
				next_st.trim_st = flash_regs_pkg::TR_DONE;
			end
			default: begin
				next_st.trim_st = flash_regs_pkg::TR_IDLE;
			end
		endcase

		// Write lands at the answering edge, where waitrequest is low
		if (st.ack && avs_write_i && avs_byteenable_i[0]) begin
			if (avs_address_i == {1'b0, `OFS_ACCESS_SIZE}) begin
				// Prohibited codes are stored as written
				next_st.ctrl.access_size = avs_writedata_i[1:0];
			end else if (avs_address_i == {1'b0, `OFS_READ_WAIT}) begin
				next_st.ctrl.read_wait = {avs_writedata_i[1], 1'b0};
			end else if (avs_address_i == {1'b0, `OFS_STATUS}) begin
				if (!avs_writedata_i[`ST_ERR_BIT]) begin
					next_st.ctrl.ecc_err = 1'b0;
				end
			end else if (avs_address_i == {1'b0, `OFS_EXTRA_WAIT}) begin
				next_st.ctrl.extra_wait = avs_writedata_i[2:0];
			end
		end
		// Set wins over a clearing write in the same cycle
		if (st.ecc_s2) begin
			next_st.ctrl.ecc_err = 1'b1;
		end

		next_st.rdata = 32'h0000_0000;
		if (req && avs_read_i) begin
			if (avs_address_i == {1'b0, `OFS_ACCESS_SIZE}) begin
				next_st.rdata[1:0] = st.ctrl.access_size;
			end else if (avs_address_i == {1'b0, `OFS_READ_WAIT}) begin
				next_st.rdata[1:0] = st.ctrl.read_wait;
			end else if (avs_address_i == {1'b0, `OFS_STATUS}) begin
				// Reserved status bits read zero
				next_st.rdata[`ST_ERR_BIT] = st.ctrl.ecc_err;
				next_st.rdata[`ST_HNG_BIT] = st.hng_s2;
				next_st.rdata[`ST_RDY_BIT] = ~st.bsy_s2;
			end else if (avs_address_i == {1'b0, `OFS_EXTRA_WAIT}) begin
				next_st.rdata[2:0] = st.ctrl.extra_wait;
			end else if (avs_address_i == `OFS_TRIM) begin
				next_st.rdata[9:0] = st.ctrl.trim;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.ctrl.access_size <= `ASZ_RESET;
			st.ctrl.read_wait <= `RWT_RESET;
			st.ctrl.extra_wait <= `SD_RESET;
			st.ctrl.trim <= 10'h000;
			st.trim_st <= flash_regs_pkg::TR_IDLE;
			st.rd32 <= 1'b1;
			st.bsy_s1 <= 1'b1;
			st.bsy_s2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata_o    = st.rdata;
	assign avs_waitrequest_o = ~st.ack;
	assign flash_rd_done_o   = st.rdone;
	assign prog_mode_o       = st.prog;
	assign read32_mode_o     = st.rd32;
	assign read_waits_o      = st.waits;
	assign trim_rd_o         = st.trim_rd;
	assign trim_o            = st.ctrl.trim;
endmodule : flash_interface_regs

// ===== testbench/flash_interface_regs_checker.sv
// Mode, wait and trim timing checks of the flash register bank
module flash_interface_regs_checker (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic       flash_rd_req_i,
	input wire logic       flash_rd_done_o,
	input wire logic       prog_mode_o,
	input wire logic       read32_mode_o,
	input wire logic [3:0] read_waits_o,
	input wire logic [9:0] trim_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence quick_rd_s;
		flash_rd_req_i && read32_mode_o && read_waits_o == 4'h0;
	endsequence
	rst_mode_a: assert property (
		$fell(sys_rst_i) |-> read32_mode_o) else $error("no rom mode");
	one_mode_a: assert property (
		!(prog_mode_o && read32_mode_o)) else $error("two modes");
	waits_off_a: assert property (
		!read32_mode_o [*3] |-> !read_waits_o) else $error("stray waits");
	wait_code_a: assert property (
		read_waits_o inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h7})
		else $error("bad waits");
	quick_rd_a: assert property (
		quick_rd_s |-> ##3 flash_rd_done_o) else $error("late read");
	prog_rd_a: assert property (
		flash_rd_req_i && prog_mode_o |=> flash_rd_done_o)
		else $error("late read");
	trim_clear_a: assert property (
		$fell(sys_rst_i) |-> !trim_o) else $error("trim kept");
	rst_waits_a: assert property (
		$fell(sys_rst_i) |-> !read_waits_o) else $error("waits kept");
endmodule : flash_interface_regs_checker
bind flash_interface_regs flash_interface_regs_checker
	flash_interface_regs_checker_i (.clk_i, .sys_rst_i, .flash_rd_req_i,
	.flash_rd_done_o, .prog_mode_o, .read32_mode_o, .read_waits_o, .trim_o);

// ===== testbench/flash_array_model.sv
// Flash array stand-in that answers the trim word fetch
module flash_array_model #(parameter logic [31:0] WORD = 32'h5a5a_a2b6) (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	output logic      [31:0] data_o,
	output logic             valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial valid_o = 1'b0;
	initial data_o = 32'h0000_0000;
	// Idle lines toggle so a stale word never passes for data
	always @(posedge clk_i) begin
		valid_o <= rd_i && !valid_o;
		data_o <= rd_i && !valid_o ? WORD : ~data_o;
	end
endmodule : flash_array_model

// ===== testbench/flash_interface_regs_bench.sv
// Bus level scenarios for the flash register bank
module flash_interface_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] WORD = 32'h5a5a_a2b6;
	localparam logic [31:0] TRIM = WORD & 32'h0000_03ff;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, ecc_corr_i = 1'b0;
	logic        avs_read_i = 1'b0, avs_write_i = 1'b0, hang_i = 1'b0;
	logic        busy_i = 1'b0, flash_rd_req_i = 1'b0;
	logic [4:0]  avs_address_i = 5'h00;
	logic [3:0]  avs_byteenable_i = 4'hf, read_waits_o;
	logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, trim_data_i;
	logic        avs_waitrequest_o, flash_rd_done_o, prog_mode_o;
	logic        read32_mode_o, trim_rd_o, trim_valid_i;
	logic [9:0]  trim_o;
	int          n_fail = 0, n_checks = 0, cyc = 0;
	bit          skip = 1'b0;
	flash_interface_regs flash_interface_regs_i (.clk_i, .sys_rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.ecc_corr_i, .hang_i, .busy_i, .flash_rd_req_i, .flash_rd_done_o,
		.prog_mode_o, .read32_mode_o, .read_waits_o, .trim_rd_o,
		.trim_data_i, .trim_valid_i, .trim_o);
	flash_array_model #(.WORD(WORD)) flash_array_model_i (.clk_i,
		.rd_i(trim_rd_o), .data_o(trim_data_i), .valid_o(trim_valid_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Reads compare against d, so one task serves both directions
	task automatic bus(input logic w, logic [4:0] a, logic [31:0] d);
		@(posedge clk_i) {avs_write_i, avs_read_i} <= {w, !w};
		{avs_address_i, avs_writedata_i} <= {a, d};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		if (!w && !skip) check("register", avs_readdata_o, d);
		{avs_write_i, avs_read_i} <= 2'h0;
	endtask : bus
	task automatic rd_time(input int n);
		int k = 0;
		@(posedge clk_i) flash_rd_req_i <= 1'b1;
		@(posedge clk_i) flash_rd_req_i <= 1'b0;
		do @(posedge clk_i) k++; while (flash_rd_done_o !== 1'b1);
		check("latency", 32'(k), 32'(n));
	endtask : rd_time
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) n_fail++;
		if (cyc == 5000) print_verdict();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		bus(1'b0, 5'h00, 32'h0000_0002);
		for (int c = 3; c >= 0; c--) begin
			bus(1'b1, 5'h00, 32'h0000_00fc | c);
			bus(1'b0, 5'h00, 32'(c));
			check("modes", 32'({read32_mode_o, prog_mode_o}), 32'(c % 3));
			if (c == 1) rd_time(1);
		end
		bus(1'b1, 5'h04, 32'h0000_00ff);
		bus(1'b0, 5'h04, 32'h0000_0002);
		bus(1'b1, 5'h04, 32'h0000_0000);
		avs_byteenable_i <= 4'h0;
		bus(1'b1, 5'h00, 32'h0000_0002);
		avs_byteenable_i <= 4'hf;
		bus(1'b0, 5'h00, 32'h0000_0000);
		bus(1'b1, 5'h00, 32'h0000_0002);
		bus(1'b0, 5'h00, 32'h0000_0002);
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, 5'h0c, 32'(s));
			bus(1'b0, 5'h0c, 32'(s));
			check("waits", 32'(read_waits_o), 32'(s % 2 * s));
			rd_time(s % 2 * s + 3);
		end
		ecc_corr_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		ecc_corr_i <= 1'b0;
		bus(1'b0, 5'h08, 32'h0000_0005);
		bus(1'b1, 5'h08, 32'h0000_00fc);
		bus(1'b0, 5'h08, 32'h0000_0005);
		{hang_i, busy_i} <= 2'h3;
		// First status read after a command may be stale
		skip = 1'b1;
		bus(1'b0, 5'h08, 32'h0000_0000);
		skip = 1'b0;
		bus(1'b1, 5'h08, 32'h0000_0000);
		bus(1'b0, 5'h08, 32'h0000_0002);
		{hang_i, busy_i} <= 2'h0;
		repeat (2) @(posedge clk_i);
		bus(1'b0, 5'h08, 32'h0000_0001);
		bus(1'b0, 5'h14, 32'h0000_0000);
		bus(1'b1, 5'h10, 32'h0000_0000);
		bus(1'b0, 5'h10, TRIM);
		bus(1'b1, 5'h00, 32'h0000_0001);
		bus(1'b0, 5'h00, 32'h0000_0001);
		check("prog", 32'(prog_mode_o), 32'h0000_0001);
		avs_byteenable_i <= 4'h3;
		bus(1'b1, 5'h0c, 32'h0000_0003);
		avs_byteenable_i <= 4'hf;
		bus(1'b0, 5'h0c, 32'h0000_0003);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("trim", 32'(trim_o), 32'h0000_0000);
		sys_rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		check("trim", 32'(trim_o), TRIM);
		check("fetch", 32'(trim_rd_o), 32'h0000_0000);
		bus(1'b0, 5'h00, 32'h0000_0002);
		bus(1'b0, 5'h0c, 32'h0000_0000);
		print_verdict();
	end
endmodule : flash_interface_regs_bench
